// ### verilog/tick_timer_pkg.sv
`default_nettype none
package tick_timer_pkg;
    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int COUNT_W = 24;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int BYTE_W = 8;
    localparam int EVT_W = 2;

    // ----------------------------------------------------------------
    // Address map: region bounds and byte offsets inside it
    // ----------------------------------------------------------------
    localparam logic [31:0] REGION_BASE = 32'hE000_E010;
    localparam logic [31:0] REGION_LAST = 32'hE000_E0FF;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_RELOAD = 8'h14;
    localparam logic [7:0] OFS_CURRENT = 8'h18;
    localparam logic [7:0] OFS_INT_STAT = 8'h20;
    localparam logic [7:0] OFS_INT_CLR = 8'h24;
    localparam logic [7:0] OFS_INT_EN = 8'h28;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_SRC_BIT = 2;
    localparam int CTRL_FLAG_BIT = 16;
    localparam int EVT_ZERO_BIT = 0;
    localparam int EVT_WRAP_BIT = 1;

    // ----------------------------------------------------------------
    // Reset values and constants
    // ----------------------------------------------------------------
    localparam logic [COUNT_W-1:0] COUNT_RST = 24'h00_0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h00_0001;
    localparam logic [COUNT_W-1:0] RELOAD_RST = 24'h00_0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [EVT_W-1:0] EVT_ZERO = 2'h0;

    // State of the timer top, apart from the interrupt status bits held in sticky_event
    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic [COUNT_W-1:0] reload;
        logic enable;
        logic src_sel;
        logic flag;
        logic [EVT_W-1:0] int_en;
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } timer_state_s;

    // State of the tick source stage
    typedef struct packed {
        logic ext_prev;
    } tick_state_s;
endpackage
`default_nettype wire

// ### verilog/tick_source.sv
`timescale 1ns/100ps
`default_nettype none
module tick_source (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ext_tick,
    input wire logic src_sel,
    output logic tick
);
    tick_timer_pkg::tick_state_s cur;
    tick_timer_pkg::tick_state_s nxt;

    // ----------------------------------------------------------------
    // Edge detect on the external tick
    // ----------------------------------------------------------------
    // Core clock ticks every cycle; external source ticks on rising edge
    always_comb begin
        nxt = cur;
        nxt.ext_prev = ext_tick;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign tick = src_sel ? (ext_tick & ~cur.ext_prev) : 1'b1; // [R12]
endmodule
`default_nettype wire

// ### verilog/sticky_event.sv
`timescale 1ns/100ps
`default_nettype none
module sticky_event (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set,
    input wire logic clr,
    output logic flag
);
    logic flag_reg;
    logic flag_next;

    // Set beats a clear that lands in the same cycle
    always_comb begin
        flag_next = set | (flag_reg & ~clr);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
endmodule
`default_nettype wire

// ### verilog/system_tick_timer.sv
// Notes on behaviour
// R1: 24-bit down-counter that wraps at zero; current value write clears it.
// R2: When enabled, count decrements by one on each tick down to zero.
// R3: Tick after reaching zero loads reload value, then keeps decrementing.
// R4: Count changing to zero sets the sticky zero-reached flag.
// R5: Reading control/status clears the zero-reached flag.
// R6: Any write to current value clears count; data is not loaded.
// R7: Current count need not reset to a defined value.
// R8: Software clears current value before enabling the timer.
// R9: Reload value zero holds count at zero after the reload.
// R10: Registers decode inside the region starting at the timer base.
// R11: Multi-byte values are little-endian; lowest address holds low byte.
// R12: Source-select bit picks core clock or external tick.
// R13: Current value write clears flag; bits above 23 read zero.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module system_tick_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic ext_tick,
    output logic irq
);
    tick_timer_pkg::timer_state_s cur;
    tick_timer_pkg::timer_state_s nxt;

    logic tick;
    logic hit;
    logic mapped;
    logic [7:0] ofs;
    logic setup;
    logic wr_done;
    logic rd_done;
    logic [31:0] rd_mux;
    logic [31:0] rld_merged;
    logic [31:0] ctl_merged;
    logic [31:0] en_merged;
    logic [31:0] clr_merged;
    logic cvr_wr;
    logic tick_en;
    logic ev_zero;
    logic ev_wrap;
    logic flag_clr;
    logic [tick_timer_pkg::EVT_W-1:0] evt_set;
    logic [tick_timer_pkg::EVT_W-1:0] evt_clr;
    logic [tick_timer_pkg::EVT_W-1:0] int_stat;

    // ----------------------------------------------------------------
    // Byte-lane merge
    // ----------------------------------------------------------------
    // Lane 0 is the lowest address and the least significant byte
    function automatic logic [31:0] merge(input logic [31:0] old_val,
                                          input logic [31:0] new_val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < tick_timer_pkg::STRB_W; i++) begin
            if (strb[i]) begin
                res[i*tick_timer_pkg::BYTE_W +: tick_timer_pkg::BYTE_W] =
                    new_val[i*tick_timer_pkg::BYTE_W +:
                            tick_timer_pkg::BYTE_W]; // [R11]
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    tick_source u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .ext_tick(ext_tick),
        .src_sel(cur.src_sel),
        .tick(tick)
    );

    // One sticky interrupt status bit per event
    for (genvar g = 0; g < tick_timer_pkg::EVT_W; g++) begin : g_evt
        sticky_event u_evt (
            .pclk(pclk),
            .presetn(presetn),
            .set(evt_set[g]),
            .clr(evt_clr[g]),
            .flag(int_stat[g])
        );
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    // Only the six register offsets inside the timer region answer; everything else raises pslverr
    assign hit = (paddr >= tick_timer_pkg::REGION_BASE) &&
                 (paddr <= tick_timer_pkg::REGION_LAST); // [R10]
    assign ofs = paddr[7:0];
    assign mapped = hit && ((ofs == tick_timer_pkg::OFS_CTRL) ||
                            (ofs == tick_timer_pkg::OFS_RELOAD) ||
                            (ofs == tick_timer_pkg::OFS_CURRENT) ||
                            (ofs == tick_timer_pkg::OFS_INT_STAT) ||
                            (ofs == tick_timer_pkg::OFS_INT_CLR) ||
                            (ofs == tick_timer_pkg::OFS_INT_EN));
    assign setup = psel & ~penable;
    // Access ends in the first access cycle, so no wait states
    assign wr_done = psel & penable & cur.pready & pwrite & mapped;
    assign rd_done = psel & penable & cur.pready & ~pwrite & mapped;

    // Merged write values, lanes taken from pstrb
    assign rld_merged = merge({8'h00, cur.reload}, pwdata, pstrb);
    assign ctl_merged = merge(rd_mux, pwdata, pstrb);
    assign en_merged = merge({30'h0, cur.int_en}, pwdata, pstrb);
    assign clr_merged = merge(tick_timer_pkg::DATA_ZERO, pwdata, pstrb);

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_mux = tick_timer_pkg::DATA_ZERO;
        case (ofs)
            tick_timer_pkg::OFS_CTRL: begin
                rd_mux[tick_timer_pkg::CTRL_ENABLE_BIT] = cur.enable;
                rd_mux[tick_timer_pkg::CTRL_SRC_BIT] = cur.src_sel;
                rd_mux[tick_timer_pkg::CTRL_FLAG_BIT] = cur.flag;
            end
            tick_timer_pkg::OFS_RELOAD: begin
                rd_mux[tick_timer_pkg::COUNT_W-1:0] = cur.reload; // [R13]
            end
            tick_timer_pkg::OFS_CURRENT: begin
                rd_mux[tick_timer_pkg::COUNT_W-1:0] = cur.count; // [R13]
            end
            tick_timer_pkg::OFS_INT_STAT: begin
                rd_mux[tick_timer_pkg::EVT_W-1:0] = int_stat;
            end
            tick_timer_pkg::OFS_INT_EN: begin
                rd_mux[tick_timer_pkg::EVT_W-1:0] = cur.int_en;
            end
            default: begin
                rd_mux = tick_timer_pkg::DATA_ZERO;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Counter events
    // ----------------------------------------------------------------
    // A current-value write overrides a tick in the same cycle
    assign cvr_wr = wr_done && (ofs == tick_timer_pkg::OFS_CURRENT); // [R6]
    assign tick_en = cur.enable & tick & ~cvr_wr; // [R2]
    // Reload of zero from zero is no change, so no flag then
    assign ev_zero = tick_en &&
                     (cur.count == tick_timer_pkg::COUNT_ONE); // [R4]
    assign ev_wrap = tick_en &&
                     (cur.count == tick_timer_pkg::COUNT_RST); // [R3]
    // Clear only a flag value that the read actually returned
    assign flag_clr = (rd_done && (ofs == tick_timer_pkg::OFS_CTRL) &&
                       cur.prdata[tick_timer_pkg::CTRL_FLAG_BIT]) ||
                      cvr_wr; // [R5] [R13]

    always_comb begin
        evt_set = tick_timer_pkg::EVT_ZERO;
        evt_set[tick_timer_pkg::EVT_ZERO_BIT] = ev_zero;
        evt_set[tick_timer_pkg::EVT_WRAP_BIT] = ev_wrap;
        evt_clr = tick_timer_pkg::EVT_ZERO;
        if (wr_done && (ofs == tick_timer_pkg::OFS_INT_CLR)) begin
            evt_clr = clr_merged[tick_timer_pkg::EVT_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt = cur;
        // Bus answer prepared in the setup cycle
        nxt.pready = setup;
        if (setup) begin
            nxt.pslverr = ~mapped;
            nxt.prdata = (pwrite || !mapped) ?
                         tick_timer_pkg::DATA_ZERO : rd_mux;
        end
        // Counter
        if (cvr_wr) begin
            nxt.count = tick_timer_pkg::COUNT_RST; // [R1] [R6]
        end else if (tick_en) begin
            if (cur.count == tick_timer_pkg::COUNT_RST) begin
                nxt.count = cur.reload; // [R3] [R9]
            end else begin
                nxt.count = cur.count - tick_timer_pkg::COUNT_ONE; // [R2]
            end
        end
        // Sticky flag; a new zero beats a clear
        nxt.flag = ev_zero | (cur.flag & ~flag_clr); // [R4] [R5]
        // Register writes
        if (wr_done) begin
            case (ofs)
                tick_timer_pkg::OFS_CTRL: begin
                    nxt.enable =
                        ctl_merged[tick_timer_pkg::CTRL_ENABLE_BIT];
                    nxt.src_sel =
                        ctl_merged[tick_timer_pkg::CTRL_SRC_BIT]; // [R12]
                end
                tick_timer_pkg::OFS_RELOAD: begin
                    nxt.reload =
                        rld_merged[tick_timer_pkg::COUNT_W-1:0]; // [R11]
                end
                tick_timer_pkg::OFS_INT_EN: begin
                    nxt.int_en = en_merged[tick_timer_pkg::EVT_W-1:0];
                end
                default: begin
                    nxt.int_en = cur.int_en;
                end
            endcase
        end
        // Level interrupt from enabled status bits
        nxt.irq = |(int_stat & cur.int_en);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Count gets a defined reset value anyway; it costs nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur.count <= tick_timer_pkg::COUNT_RST; // [R7]
            cur.reload <= tick_timer_pkg::RELOAD_RST;
            cur.enable <= 1'b0;
            cur.src_sel <= 1'b0;
            cur.flag <= 1'b0;
            cur.int_en <= tick_timer_pkg::EVT_ZERO;
            cur.prdata <= tick_timer_pkg::DATA_ZERO;
            cur.pready <= 1'b0;
            cur.pslverr <= 1'b0;
            cur.irq <= 1'b0;
        end else begin
            cur <= nxt;
        end
    end

    assign pready = cur.pready;
    assign prdata = cur.prdata;
    assign pslverr = cur.pslverr;
    assign irq = cur.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_count_decrement: assert property ( // [R2]
        tick_en && (cur.count > tick_timer_pkg::COUNT_ONE)
        |=> cur.count == $past(cur.count) - tick_timer_pkg::COUNT_ONE)
        else $error("count did not decrement by one");

    a_wrap_reload: assert property ( // [R3]
        tick_en && (cur.count == tick_timer_pkg::COUNT_RST)
        |=> cur.count == $past(cur.reload))
        else $error("count did not reload after zero");

    a_wrap_status: assert property ( // [R3]
        ev_wrap |=> int_stat[tick_timer_pkg::EVT_WRAP_BIT])
        else $error("wrap event not recorded");

    a_flag_on_zero: assert property ( // [R4]
        tick_en && (cur.count == tick_timer_pkg::COUNT_ONE)
        |=> (cur.count == tick_timer_pkg::COUNT_RST) && cur.flag)
        else $error("zero reached flag not set");

    a_read_clears: assert property ( // [R5]
        rd_done && (ofs == tick_timer_pkg::OFS_CTRL) &&
        prdata[tick_timer_pkg::CTRL_FLAG_BIT] && !ev_zero
        |=> !cur.flag)
        else $error("flag not cleared by read");

    a_write_clears: assert property ( // [R6]
        psel && penable && pready && pwrite && hit &&
        (ofs == tick_timer_pkg::OFS_CURRENT)
        |=> (cur.count == tick_timer_pkg::COUNT_RST) && !cur.flag)
        else $error("current value write did not clear");

    // Two quiet cycles: one to take the zero reload, one to stay there
    a_zero_holds: assert property ( // [R9]
        (cur.count == tick_timer_pkg::COUNT_RST) &&
        (cur.reload == tick_timer_pkg::COUNT_RST) &&
        !wr_done ##1 !wr_done
        |=> cur.count == tick_timer_pkg::COUNT_RST)
        else $error("count left zero with zero reload");

    // Unused high bits of the count registers read back as zero
    a_upper_zero: assert property ( // [R13]
        setup && !pwrite && hit &&
        ((ofs == tick_timer_pkg::OFS_RELOAD) ||
         (ofs == tick_timer_pkg::OFS_CURRENT))
        |=> pready && ((prdata >> tick_timer_pkg::COUNT_W) ==
                       tick_timer_pkg::DATA_ZERO))
        else $error("upper bits of count read nonzero");

    a_unmapped_err: assert property ( // [R10]
        setup && !hit
        |=> pready && pslverr && (prdata == tick_timer_pkg::DATA_ZERO))
        else $error("unmapped access not refused");

    // External source: no rising edge on the pin, no move of the count
    a_ext_source: assert property ( // [R12]
        cur.src_sel && cur.enable && !ext_tick && !wr_done
        |=> $stable(cur.count))
        else $error("count moved without external tick");

    // With the core clock every enabled cycle is a tick, so the count
    // must move unless it sits at zero with a zero reload
    a_core_source: assert property ( // [R12]
        !cur.src_sel && cur.enable && !wr_done &&
        ((cur.count != tick_timer_pkg::COUNT_RST) ||
         (cur.reload != tick_timer_pkg::COUNT_RST))
        |=> $changed(cur.count))
        else $error("count idle on core clock source");

    a_zero_status: assert property ( // [R4]
        ev_zero |=> int_stat[tick_timer_pkg::EVT_ZERO_BIT] && cur.flag)
        else $error("zero event not recorded");

    a_flag_sticky: assert property ( // [R4]
        cur.flag && !flag_clr |=> cur.flag)
        else $error("flag dropped without a clear");

    // Level interrupt trails the enabled status by one cycle
    a_irq_level: assert property ( // [R4]
        (|(int_stat & cur.int_en)) |=> irq)
        else $error("interrupt not raised");

    a_irq_quiet: assert property ( // [R4]
        !(|(int_stat & cur.int_en)) |=> !irq)
        else $error("interrupt raised with no enabled status");

    a_ready_pulse: assert property ( // [R10]
        pready |=> !pready)
        else $error("pready held beyond one cycle");
endmodule
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ------------------------------------------------------------
    // Signals and short names for the register offsets
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, ext_tick;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr, irq;
    int mismatches = 0;
    int total_checks = 0;
    logic [31:0] rd, d;
    logic er;
    logic [23:0] n;
    logic [25:0] m;
    int k;
    localparam logic [23:0] HI = tick_timer_pkg::REGION_BASE[31:8];
    localparam logic [7:0] CTL = tick_timer_pkg::OFS_CTRL;
    localparam logic [7:0] RLD = tick_timer_pkg::OFS_RELOAD;
    localparam logic [7:0] CUR = tick_timer_pkg::OFS_CURRENT;
    localparam logic [7:0] IST = tick_timer_pkg::OFS_INT_STAT;
    localparam logic [7:0] ICL = tick_timer_pkg::OFS_INT_CLR;
    localparam logic [7:0] IEN = tick_timer_pkg::OFS_INT_EN;

    system_tick_timer DUT (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .ext_tick(ext_tick),
        .irq(irq)
    );

    // 100 ns core clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Checking, bus and tick tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; the wait for pready is bounded so a hang shows
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] wd, input logic [3:0] st);
        int c = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            c++;
        end while (pready !== 1'b1 && c < 16);
        // A slave that never answers ends the run at once
        if (pready !== 1'b1) begin
            chk("pready", {31'h0, pready}, 32'h1);
            summarize();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] o, input logic [31:0] dat);
        xfer(1'b1, {HI, o}, dat, 4'hF);
    endtask

    task automatic rdc(input string name, input logic [7:0] o,
                       input logic [31:0] e);
        xfer(1'b0, {HI, o}, 32'h0, 4'h0);
        chk(name, rd, e);
    endtask

    // Each pulse is one rising edge; idle cycles let the edge detect land
    task automatic ticks(input int cnt);
        repeat (cnt) begin
            @(posedge pclk);
            ext_tick <= 1'b1;
            @(posedge pclk);
            ext_tick <= 1'b0;
        end
        repeat (3) @(posedge pclk);
    endtask

    // Expected {wrap, flag, count} after cnt ticks starting from zero
    function automatic logic [25:0] model(input logic [23:0] rl,
                                          input int cnt);
        logic [23:0] c;
        logic f, w;
        c = 24'h0;
        f = 1'b0;
        w = 1'b0;
        for (int i = 0; i < cnt; i++) begin
            if (c == 24'h0) begin
                c = rl;
                w = 1'b1;
            end else begin
                c = c - 24'h1;
                f = f | (c == 24'h0);
            end
        end
        return {w, f, c};
    endfunction

    // ------------------------------------------------------------
    // Watchdog: the run needs a few thousand cycles at most
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, ext_tick} = 4'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        void'($urandom(5));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state
        rdc("ctrl_rst", CTL, 32'h0);
        rdc("reload_rst", RLD, 32'h0);
        rdc("stat_rst", IST, 32'h0);
        chk("irq_rst", {31'h0, irq}, 32'h0);
        // Decode: unused offset and an address below the region
        xfer(1'b0, {HI, 8'h1C}, 32'h0, 4'h0);
        chk("unused_err", {31'h0, er}, 32'h1);
        chk("unused_data", rd, 32'h0);
        xfer(1'b1, 32'hE000_E00C, 32'hFFFF_FFFF, 4'hF);
        chk("below_err", {31'h0, er}, 32'h1);
        rdc("reload_kept", RLD, 32'h0);
        chk("mapped_err", {31'h0, er}, 32'h0);
        // Byte lanes land little-endian; the top byte is not stored
        xfer(1'b1, {HI, RLD}, 32'h0000_AB00, 4'h2);
        xfer(1'b1, {HI, RLD}, 32'h0000_00CD, 4'h1);
        xfer(1'b1, {HI, RLD}, 32'hFF00_0000, 4'h8);
        rdc("reload_lanes", RLD, 32'h0000_ABCD);
        // Core clock source: count stays within reload, flag gets set
        wr(CUR, 32'hFFFF_FFFF);
        wr(RLD, 32'h3);
        wr(CTL, 32'h1);
        repeat (20) @(posedge pclk);
        wr(CTL, 32'h0);
        xfer(1'b0, {HI, CUR}, 32'h0, 4'h0);
        chk("core_count", {31'h0, rd <= 32'h3}, 32'h1);
        rdc("core_flag", CTL, 32'h0001_0000);
        rdc("core_flag_rd", CTL, 32'h0);
        // External tick source with random reloads, zero included
        wr(CUR, 32'h0);
        wr(CTL, 32'h5);
        for (int it = 0; it < 12; it++) begin
            // First pass forces the zero reload corner
            n = (it == 0) ? 24'h0 : 24'($urandom_range(6, 0));
            k = int'($urandom_range(14, 1));
            d = $urandom();
            d[23:0] = n;
            wr(RLD, d);
            rdc("reload", RLD, {8'h00, n});
            wr(CUR, $urandom());
            wr(ICL, 32'h3);
            rdc("cur_clear", CUR, 32'h0);
            ticks(k);
            m = model(n, k);
            rdc("count", CUR, {8'h00, m[23:0]});
            rdc("stat", IST, {30'h0, m[25], m[24]});
            rdc("flag", CTL, {15'h0, m[24], 13'h0, 3'h5});
            rdc("flag_rd", CTL, 32'h5);
        end
        // Interrupt: raise, mask, unmask, clear
        wr(RLD, 32'h2);
        wr(CUR, 32'h0);
        wr(ICL, 32'h3);
        wr(IEN, 32'h1);
        rdc("int_en", IEN, 32'h1);
        ticks(3);
        chk("irq_set", {31'h0, irq}, 32'h1);
        wr(IEN, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq_mask", {31'h0, irq}, 32'h0);
        wr(IEN, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq_unmask", {31'h0, irq}, 32'h1);
        wr(CUR, 32'h0);
        rdc("flag_wr_clr", CTL, 32'h5);
        wr(ICL, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        rdc("stat_clr", IST, 32'h2);
        rdc("clr_reads", ICL, 32'h0);
        // Wrap status alone drives the interrupt once its enable is set
        wr(IEN, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq_wrap", {31'h0, irq}, 32'h1);
        summarize();
    end
endmodule
`default_nettype wire
